// ===== rtl/auxdf_pkg.sv
// package: register map, field layout and filter constants of the auxiliary decimation filter
package auxdf_pkg;
   // register offsets (byte-wide registers on a plain port)
   localparam logic [7:0] ADDR_AUX_INPUT_MUX = 8'h16;
   localparam logic [7:0] ADDR_AUX_GAIN_RATE_CONFIG = 8'h17;
   localparam logic [7:0] ADDR_AUX_STATUS = 8'h18;
   localparam logic [7:0] ADDR_AUX_DATA0 = 8'h19;
   localparam logic [7:0] ADDR_AUX_DATA1 = 8'h1A;
   localparam logic [7:0] ADDR_AUX_DATA2 = 8'h1B;
   // aux_input_mux fields
   localparam int POS_SEL_LSB = 4;
   localparam int NEG_SEL_LSB = 0;
   localparam logic [7:0] MUX_RESET = 8'h01;
   // aux_gain_rate_config fields
   localparam int REF_SEL_LSB = 5;
   localparam int RATE_LSB = 3;
   localparam int GAIN_LSB = 0;
   localparam logic [7:0] CFG_RESET = 8'h00;
   // reference choices
   localparam logic [2:0] REF_EXT_01 = 3'h0;
   localparam logic [2:0] REF_EXT_23 = 3'h1;
   localparam logic [2:0] REF_EXT_45 = 3'h2;
   localparam logic [2:0] REF_INTERNAL = 3'h3;
   localparam logic [2:0] REF_SUPPLY = 3'h4;
   // rate codes
   localparam logic [1:0] RATE_10 = 2'h0;
   localparam logic [1:0] RATE_100 = 2'h1;
   localparam logic [1:0] RATE_400 = 2'h2;
   localparam logic [1:0] RATE_800 = 2'h3;
   localparam int RATIO_A_10 = 512;
   localparam int RATIO_A_100 = 512;
   localparam int RATIO_A_400 = 128;
   localparam int RATIO_A_800 = 64;
   localparam int RATIO_B = 10;
   // gains at or below this code run with the amplifier bypassed
   localparam logic [2:0] GAIN_BYPASS_MAX = 3'h2;
   // modulator sample period in converter clocks
   localparam int MOD_DIV = 144;
   localparam int CIC_WIDTH = 29;
   localparam int OUT_WIDTH = 24;
   // largest and smallest 24-bit results
   localparam logic signed [23:0] OUT_MAX = 24'sh7FFFFF;
   localparam logic signed [23:0] OUT_MIN = 24'sh800000;
   localparam int SUM_WIDTH = 32;
endpackage : auxdf_pkg

// ===== rtl/auxdf_sinc1.sv
// second stage: first-order sinc decimator by ten
`timescale 1ns/100ps
`default_nettype none
module auxdf_sinc1
#(
   parameter int IN_WIDTH = 24,
   parameter int SUM_WIDTH = 32,
   parameter int RATIO = 10
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic in_valid,
   input wire logic signed [IN_WIDTH-1:0] in_data,
   output logic out_valid,
   output logic signed [IN_WIDTH-1:0] out_data
);
   logic signed [SUM_WIDTH-1:0] acc_reg;
   logic [3:0] cnt_reg;
   logic signed [SUM_WIDTH-1:0] total;

   assign total = acc_reg + SUM_WIDTH'(in_data);

   always_ff @(posedge clk)
   begin
      if (!rst_n || clear)
      begin
         acc_reg <= '0;
         cnt_reg <= 4'h0;
         out_valid <= 1'b0;
         out_data <= '0;
      end
      else
      begin
         out_valid <= 1'b0;
         if (in_valid)
         begin
            if (cnt_reg == 4'(RATIO - 1))
            begin
               // plain average of ten results
               out_data <= IN_WIDTH'(total / RATIO);
               out_valid <= 1'b1;
               acc_reg <= '0;
               cnt_reg <= 4'h0;
            end
            else
            begin
               acc_reg <= total;
               cnt_reg <= cnt_reg + 4'h1;
            end
         end
      end
   end
endmodule : auxdf_sinc1
`default_nettype wire

// ===== rtl/auxdf_top.sv
// top: configuration registers, sinc3 decimator and result registers of the auxiliary converter
// =====================================================================
// What this block does
// RQ1: positive input channel follows the 4-bit positive-select field of the mux register.
// RQ2: negative input channel follows the 4-bit negative-select field, same register.
// RQ3: input mux register sits at address 16h.
// RQ4: aux mux is independent of the main mux, same channel choices.
// RQ5: gains 1, 2, 4 bypass the amplifier; higher gains enable it.
// RQ6: 3-bit gain code means gain two to the power of code.
// RQ7: reference selector picks exactly one of five sources.
// RQ8: external reference pairs are inputs 0-1, 2-3, 4-5, first positive.
// RQ9: modulator sampled every 144 converter clocks, one-bit stream in.
// RQ10: filter low-passes, decimates and gives a 24-bit result.
// RQ11: first stage sinc3 decimates by 64, 128 or 512.
// RQ12: second stage sinc1 decimates the 100 SPS stream by ten.
// RQ13: second stage bypassed at 800, 400 and 100 SPS.
// RQ14: total ratio is first ratio times second (one when bypassed).
// RQ15: rate codes 00..11 give 10, 100, 400, 800 SPS; 00 at reset.
// RQ16: output rates scale with the converter clock.
// RQ17: response is sinc cubed times the second-stage sinc.
// RQ18: sinc3 built as three integrators then three differentiators, wide enough.
// RQ19: rate change clears accumulators and drops partial results.
`timescale 1ns/100ps
`default_nettype none
module auxdf_top
#(
   parameter int MOD_DIV = auxdf_pkg::MOD_DIV
)
(
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic MOD_BIT,
   output logic MOD_SAMPLE,
   output logic [3:0] AUX_POSITIVE_SELECT,
   output logic [3:0] AUX_NEGATIVE_SELECT,
   output logic [2:0] AUX_GAIN_CODE,
   output logic [1:0] MOD_GAIN_CODE,
   output logic AMP_ENABLE,
   output logic [4:0] REF_SELECT_ONEHOT,
   output logic DATA_VALID,
   output logic [23:0] DATA_OUT
);
   localparam int CW = auxdf_pkg::CIC_WIDTH;
   localparam int OW = auxdf_pkg::OUT_WIDTH;

   // =====================================================================
   // helpers
   function automatic logic [9:0] ratio_a(input logic [1:0] rate);
      unique case (rate)
         auxdf_pkg::RATE_10: ratio_a = 10'(auxdf_pkg::RATIO_A_10);
         auxdf_pkg::RATE_100: ratio_a = 10'(auxdf_pkg::RATIO_A_100);
         auxdf_pkg::RATE_400: ratio_a = 10'(auxdf_pkg::RATIO_A_400);
         auxdf_pkg::RATE_800: ratio_a = 10'(auxdf_pkg::RATIO_A_800);
      endcase
   endfunction : ratio_a

   // shift that scales the sinc3 gain A^3 to a full 24-bit result at ratio 512; ratios 128 and 64 are not shifted
   function automatic logic [4:0] out_shift(input logic [1:0] rate);
      unique case (rate)
         auxdf_pkg::RATE_400: out_shift = 5'h00;
         auxdf_pkg::RATE_800: out_shift = 5'h00;
         default: out_shift = 5'h04;
      endcase
   endfunction : out_shift

   // a steady all-ones stream at ratio 512 lands one step above the top 24-bit code;
   // clamping keeps it from wrapping round to negative full scale
   function automatic logic signed [OW-1:0] clamp_out(input logic signed [CW-1:0] value);
      if (value > CW'(auxdf_pkg::OUT_MAX))
         clamp_out = auxdf_pkg::OUT_MAX;
      else if (value < CW'(auxdf_pkg::OUT_MIN))
         clamp_out = auxdf_pkg::OUT_MIN;
      else
         clamp_out = OW'(value);
   endfunction : clamp_out

   // =====================================================================
   // registers
   logic [7:0] mux_reg;
   logic [7:0] cfg_reg;
   logic [1:0] rate_reg;
   logic rate_change;
   logic [23:0] result_reg;
   logic fresh_reg;
   logic [7:0] rdata_next;
   logic [1:0] new_rate;

   assign new_rate = WDATA[auxdf_pkg::RATE_LSB +: 2];
   assign rate_change = WR && (ADDR == auxdf_pkg::ADDR_AUX_GAIN_RATE_CONFIG) && (new_rate != rate_reg);

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         mux_reg <= auxdf_pkg::MUX_RESET;
         cfg_reg <= auxdf_pkg::CFG_RESET;
      end
      else if (WR)
      begin
         if (ADDR == auxdf_pkg::ADDR_AUX_INPUT_MUX) // RQ3
            mux_reg <= WDATA;
         if (ADDR == auxdf_pkg::ADDR_AUX_GAIN_RATE_CONFIG)
         begin
            // reference codes above the last choice fall back to the internal one
            cfg_reg <= WDATA;
            if (WDATA[auxdf_pkg::REF_SEL_LSB +: 3] > auxdf_pkg::REF_SUPPLY)
               cfg_reg[auxdf_pkg::REF_SEL_LSB +: 3] <= auxdf_pkg::REF_INTERNAL; // RQ7
         end
      end
   end

   assign rate_reg = cfg_reg[auxdf_pkg::RATE_LSB +: 2]; // RQ15

   // =====================================================================
   // analog front-end controls
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         AUX_POSITIVE_SELECT <= 4'h0;
         AUX_NEGATIVE_SELECT <= 4'h0;
      end
      else
      begin
         // own select lines: nothing is shared with the main converter
         AUX_POSITIVE_SELECT <= mux_reg[auxdf_pkg::POS_SEL_LSB +: 4]; // RQ1 RQ4
         AUX_NEGATIVE_SELECT <= mux_reg[auxdf_pkg::NEG_SEL_LSB +: 4]; // RQ2 RQ4
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         AUX_GAIN_CODE <= 3'h0;
         MOD_GAIN_CODE <= 2'h0;
         AMP_ENABLE <= 1'b0;
      end
      else
      begin
         AUX_GAIN_CODE <= cfg_reg[auxdf_pkg::GAIN_LSB +: 3]; // RQ6
         if (cfg_reg[auxdf_pkg::GAIN_LSB +: 3] <= auxdf_pkg::GAIN_BYPASS_MAX)
         begin
            AMP_ENABLE <= 1'b0; // RQ5
            MOD_GAIN_CODE <= cfg_reg[auxdf_pkg::GAIN_LSB +: 2];
         end
         else
         begin
            // modulator holds gain 4, amplifier supplies the rest
            AMP_ENABLE <= 1'b1; // RQ5
            MOD_GAIN_CODE <= auxdf_pkg::GAIN_BYPASS_MAX[1:0];
         end
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         REF_SELECT_ONEHOT <= 5'h00;
      else
         // bit 0: inputs 0/1, bit 1: 2/3, bit 2: 4/5, bit 3: internal, bit 4: supply
         REF_SELECT_ONEHOT <= 5'h01 << cfg_reg[auxdf_pkg::REF_SEL_LSB +: 3]; // RQ7 RQ8
   end

   // =====================================================================
   // modulator sample tick
   logic [7:0] div_reg;

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         div_reg <= 8'h00;
         MOD_SAMPLE <= 1'b0;
      end
      else
      begin
         MOD_SAMPLE <= (div_reg == 8'(MOD_DIV - 1)); // RQ9 RQ16
         div_reg <= (div_reg == 8'(MOD_DIV - 1)) ? 8'h00 : div_reg + 8'h01;
      end
   end

   // =====================================================================
   // sinc3: integrators at the modulator rate
   logic signed [CW-1:0] int1_reg;
   logic signed [CW-1:0] int2_reg;
   logic signed [CW-1:0] int3_reg;
   logic signed [CW-1:0] dif1_reg;
   logic signed [CW-1:0] dif2_reg;
   logic signed [CW-1:0] dif3_reg;
   logic signed [CW-1:0] d1;
   logic signed [CW-1:0] d2;
   logic signed [CW-1:0] d3;
   logic [9:0] dec_reg;
   logic [2:0] warm_reg;
   logic s3_valid;
   logic signed [OW-1:0] s3_data;
   logic signed [CW-1:0] in_val;

   // ones density mapped to +1/-1 so the result is bipolar
   assign in_val = MOD_BIT ? CW'(1) : -CW'(1);

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N || rate_change) // RQ19
      begin
         int1_reg <= '0;
         int2_reg <= '0;
         int3_reg <= '0;
         dec_reg <= 10'h000;
      end
      else if (MOD_SAMPLE)
      begin
         // 27 bits of growth at ratio 512, plus sign, plus the +A^3 end point; wrap-around cancels later
         int1_reg <= int1_reg + in_val; // RQ18
         int2_reg <= int2_reg + int1_reg; // RQ18
         int3_reg <= int3_reg + int2_reg; // RQ18
         dec_reg <= (dec_reg == ratio_a(rate_reg) - 10'h001) ? 10'h000 : dec_reg + 10'h001; // RQ11
      end
   end

   // =====================================================================
   // sinc3: differentiators at the decimated rate
   assign d1 = int3_reg - dif1_reg;
   assign d2 = d1 - dif2_reg;
   assign d3 = d2 - dif3_reg;

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N || rate_change) // RQ19
      begin
         dif1_reg <= '0;
         dif2_reg <= '0;
         dif3_reg <= '0;
         warm_reg <= 3'h0;
         s3_valid <= 1'b0;
         s3_data <= '0;
      end
      else
      begin
         s3_valid <= 1'b0;
         if (MOD_SAMPLE && dec_reg == ratio_a(rate_reg) - 10'h001)
         begin
            dif1_reg <= int3_reg; // RQ18
            dif2_reg <= d1; // RQ18
            dif3_reg <= d2; // RQ18
            s3_data <= clamp_out(d3 >>> out_shift(rate_reg)); // RQ10 RQ17
            // the first three outputs still hold settling garbage
            if (warm_reg == 3'h3)
               s3_valid <= 1'b1;
            else
               warm_reg <= warm_reg + 3'h1;
         end
      end
   end

   // =====================================================================
   // second stage and output selection
   logic s1_valid;
   logic signed [OW-1:0] s1_data;
   logic result_take;
   logic signed [OW-1:0] result_pick;

   auxdf_sinc1 #(
      .IN_WIDTH(OW),
      .SUM_WIDTH(auxdf_pkg::SUM_WIDTH),
      .RATIO(auxdf_pkg::RATIO_B)
   ) u_sinc1 (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .clear(rate_change), // RQ19
      .in_valid(s3_valid && rate_reg == auxdf_pkg::RATE_10), // RQ12
      .in_data(s3_data),
      .out_valid(s1_valid),
      .out_data(s1_data)
   );

   // at rate 00 the result comes from the second stage, otherwise straight from sinc3
   assign result_take = (rate_reg == auxdf_pkg::RATE_10) ? s1_valid : s3_valid; // RQ13 RQ14
   assign result_pick = (rate_reg == auxdf_pkg::RATE_10) ? s1_data : s3_data; // RQ13

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N || rate_change) // RQ19
      begin
         DATA_VALID <= 1'b0;
         DATA_OUT <= 24'h000000;
      end
      else
      begin
         DATA_VALID <= result_take; // RQ10
         if (result_take)
            DATA_OUT <= result_pick;
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N || rate_change) // RQ19
         result_reg <= 24'h000000;
      else if (result_take)
         result_reg <= result_pick;
   end

   // a new result in the cycle of a read of the top byte keeps the flag set
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N || rate_change)
         fresh_reg <= 1'b0;
      else if (result_take)
         fresh_reg <= 1'b1;
      else if (RD && ADDR == auxdf_pkg::ADDR_AUX_DATA0)
         fresh_reg <= 1'b0;
   end

   // =====================================================================
   // read port
   always_comb
   begin
      unique case (ADDR)
         auxdf_pkg::ADDR_AUX_INPUT_MUX: rdata_next = mux_reg;
         auxdf_pkg::ADDR_AUX_GAIN_RATE_CONFIG: rdata_next = cfg_reg;
         auxdf_pkg::ADDR_AUX_STATUS: rdata_next = {7'h00, fresh_reg};
         auxdf_pkg::ADDR_AUX_DATA0: rdata_next = result_reg[23:16];
         auxdf_pkg::ADDR_AUX_DATA1: rdata_next = result_reg[15:8];
         auxdf_pkg::ADDR_AUX_DATA2: rdata_next = result_reg[7:0];
         default: rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         RDATA <= 8'h00;
      else
         RDATA <= RD ? rdata_next : 8'h00;
   end
endmodule : auxdf_top
`default_nettype wire

// ===== tb/auxdf_checker.sv
// checker: port-level assertions of the auxiliary decimation filter
`timescale 1ns/100ps
`default_nettype none
module auxdf_checker
#(
   parameter int MOD_DIV = 144
)
(
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic MOD_SAMPLE,
   input wire logic [3:0] AUX_POSITIVE_SELECT,
   input wire logic [3:0] AUX_NEGATIVE_SELECT,
   input wire logic [2:0] AUX_GAIN_CODE,
   input wire logic [1:0] MOD_GAIN_CODE,
   input wire logic AMP_ENABLE,
   input wire logic [4:0] REF_SELECT_ONEHOT,
   input wire logic DATA_VALID
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   // ==========================================
   // counters since the last sample and result
   logic [31:0] samp_cnt_reg;
   logic samp_seen_reg;
   logic [31:0] valid_cnt_reg;
   logic valid_seen_reg;
   always_ff @(posedge REF_CLK)
   begin
      samp_cnt_reg <= (!RST_N || MOD_SAMPLE) ? 32'h0 : samp_cnt_reg + 32'h1;
      samp_seen_reg <= RST_N && (samp_seen_reg || MOD_SAMPLE);
   end
   always_ff @(posedge REF_CLK)
   begin
      valid_cnt_reg <= (!RST_N || DATA_VALID) ? 32'h0 : valid_cnt_reg + 32'h1;
      valid_seen_reg <= RST_N && (valid_seen_reg || DATA_VALID);
   end
   // ==========================================
   // assertions
   a_sample_period: assert property (MOD_SAMPLE && samp_seen_reg |-> samp_cnt_reg == MOD_DIV - 1)
      else $error("modulator sample spacing wrong");
   a_mux_follow: assert property (WR && ADDR == 8'h16 |-> ##2 {AUX_POSITIVE_SELECT, AUX_NEGATIVE_SELECT} == $past(WDATA, 2))
      else $error("input selects do not follow mux write");
   a_gain_follow: assert property (WR && ADDR == 8'h17 |-> ##2 AUX_GAIN_CODE == $past(WDATA[2:0], 2))
      else $error("gain code does not follow config write");
   a_amp_bypass: assert property (AMP_ENABLE == (AUX_GAIN_CODE > 3'h2))
      else $error("amplifier enable wrong for gain");
   a_mod_gain: assert property (MOD_GAIN_CODE == ((AUX_GAIN_CODE > 3'h2) ? 2'h2 : AUX_GAIN_CODE[1:0]))
      else $error("modulator gain wrong");
   a_ref_onehot: assert property ($past(RST_N, 2) |-> $onehot(REF_SELECT_ONEHOT))
      else $error("reference select not one-hot");
   a_rd_unmapped: assert property (RD && (ADDR < 8'h16 || ADDR > 8'h1B) |=> RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_quiet: assert property (!RD |=> RDATA == 8'h00)
      else $error("read data outside read slot");
   a_valid_pulse: assert property (DATA_VALID |=> !DATA_VALID)
      else $error("result strobe longer than one cycle");
   a_valid_spacing: assert property (DATA_VALID && valid_seen_reg |-> valid_cnt_reg >= 64 * MOD_DIV - 1)
      else $error("results closer than smallest ratio");
endmodule : auxdf_checker
bind auxdf_top auxdf_checker #(.MOD_DIV(MOD_DIV)) i_chk (.REF_CLK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA,
   .MOD_SAMPLE, .AUX_POSITIVE_SELECT, .AUX_NEGATIVE_SELECT, .AUX_GAIN_CODE, .MOD_GAIN_CODE, .AMP_ENABLE,
   .REF_SELECT_ONEHOT, .DATA_VALID);
`default_nettype wire

// ===== tb/auxdf_mod_model.sv
// partner: one-bit modulator stream, new bit after each sample edge
`timescale 1ns/100ps
`default_nettype none
module auxdf_mod_model
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sample,
   input wire logic [1:0] mode,
   output logic bit_out
);
   // mode 0 all low, 1 all high, 2 alternating
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         bit_out <= 1'b0;
      else if (sample)
         bit_out <= (mode == 2'h2) ? ~bit_out : mode[0];
   end
endmodule : auxdf_mod_model
`default_nettype wire

// ===== tb/auxdf_top_tb.sv
// testbench: register port, gain and reference decode, decimated results
`timescale 1ns/100ps
`default_nettype none
module auxdf_top_tb;
   // short sample period keeps the run small
   localparam int DIV = 4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [1:0] mode = 2'h1;
   logic rd_pend = 1'b0;
   logic [31:0] seed = 32'h0000005C;
   logic [31:0] v;
   logic [2:0] g;
   logic [2:0] r;
   int failures = 0;
   int checks_done = 0;
   logic [7:0] rq[$];
   logic [23:0] dq[$];
   wire logic [7:0] rdata;
   wire logic mbit, msamp, amp, dv;
   wire logic [3:0] pos, neg;
   wire logic [2:0] gain;
   wire logic [1:0] mgain;
   wire logic [4:0] refo;
   wire logic [23:0] dout;
   auxdf_top #(.MOD_DIV(DIV)) i_dut (.REF_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .MOD_BIT(mbit), .MOD_SAMPLE(msamp), .AUX_POSITIVE_SELECT(pos),
      .AUX_NEGATIVE_SELECT(neg), .AUX_GAIN_CODE(gain), .MOD_GAIN_CODE(mgain), .AMP_ENABLE(amp),
      .REF_SELECT_ONEHOT(refo), .DATA_VALID(dv), .DATA_OUT(dout));
   auxdf_mod_model i_mod (.clk(clk), .rst_n(rst_n), .sample(msamp), .mode(mode), .bit_out(mbit));
   always #5 clk = ~clk;
   // ==========================================
   // helpers
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic end_of_test();
      if (failures == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   // one bus cycle; for a read d is the expected data
   task automatic bus(input logic w, input logic rr, input logic [7:0] a, input logic [7:0] d);
      wr <= w;
      rd <= rr;
      addr <= a;
      wdata <= d;
      if (rr)
         rq.push_back(d);
      @(posedge clk);
   endtask : bus
   task automatic drain(input int n);
      for (int i = 0; i < n && (dq.size() != 0 || rq.size() != 0); i++)
         @(posedge clk);
      if (dq.size() != 0 || rq.size() != 0)
      begin
         failures++;
         end_of_test();
      end
   endtask : drain
   // ==========================================
   // result watcher
   always @(posedge clk)
   begin
      if (rd_pend)
         chk(rdata, rq.pop_front());
      if (dv && dq.size() != 0)
         chk(dout, dq.pop_front());
      rd_pend <= rd;
   end
   // ==========================================
   // main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, 1'b1, auxdf_pkg::ADDR_AUX_INPUT_MUX, auxdf_pkg::MUX_RESET);
      bus(1'b0, 1'b1, auxdf_pkg::ADDR_AUX_GAIN_RATE_CONFIG, auxdf_pkg::CFG_RESET);
      bus(1'b0, 1'b1, 8'h20, 8'h00);
      for (int i = 0; i < 3; i++)
      begin
         v = xs();
         bus(1'b1, 1'b0, auxdf_pkg::ADDR_AUX_INPUT_MUX, v[7:0]);
         bus(1'b0, 1'b1, auxdf_pkg::ADDR_AUX_INPUT_MUX, v[7:0]);
         bus(1'b0, 1'b0, 8'h00, 8'h00);
         chk({16'h0, pos, neg}, {16'h0, v[7:0]});
      end
      for (int i = 0; i < 8; i++)
      begin
         g = 3'(i);
         r = (g > 3'h4) ? 3'h3 : g;
         bus(1'b1, 1'b0, auxdf_pkg::ADDR_AUX_GAIN_RATE_CONFIG, {g, 2'h0, g});
         bus(1'b0, 1'b1, auxdf_pkg::ADDR_AUX_GAIN_RATE_CONFIG, {r, 2'h0, g});
         bus(1'b0, 1'b0, 8'h00, 8'h00);
         chk(24'(gain), 24'(g));
         chk(24'(amp), 24'(g > 3'h2));
         chk(24'(mgain), 24'((g > 3'h2) ? 2'h2 : g[1:0]));
         chk(24'(refo), 24'(5'h01 << r));
      end
      // rate change and new stream together, so no settled result mixes them
      mode <= 2'h1;
      bus(1'b1, 1'b0, auxdf_pkg::ADDR_AUX_GAIN_RATE_CONFIG, 8'h18);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      repeat (3) dq.push_back(24'h040000);
      drain(4000);
      bus(1'b0, 1'b1, auxdf_pkg::ADDR_AUX_STATUS, 8'h01);
      bus(1'b0, 1'b1, auxdf_pkg::ADDR_AUX_DATA0, 8'h04);
      bus(1'b0, 1'b1, auxdf_pkg::ADDR_AUX_DATA1, 8'h00);
      bus(1'b0, 1'b1, auxdf_pkg::ADDR_AUX_DATA2, 8'h00);
      bus(1'b0, 1'b1, auxdf_pkg::ADDR_AUX_STATUS, 8'h00);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      mode <= 2'h0;
      bus(1'b1, 1'b0, auxdf_pkg::ADDR_AUX_GAIN_RATE_CONFIG, 8'h10);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      repeat (2) dq.push_back(24'hE00000);
      drain(8000);
      // alternating bits cancel over any even window, so ratio 512 settles to zero
      mode <= 2'h2;
      bus(1'b1, 1'b0, auxdf_pkg::ADDR_AUX_GAIN_RATE_CONFIG, 8'h08);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      dq.push_back(24'h000000);
      drain(9000);
      // all ones at ratio 512 reaches the top code, and ten of them average to it
      mode <= 2'h1;
      bus(1'b1, 1'b0, auxdf_pkg::ADDR_AUX_GAIN_RATE_CONFIG, 8'h00);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      dq.push_back(24'h7FFFFF);
      drain(28000);
      bus(1'b1, 1'b0, auxdf_pkg::ADDR_AUX_GAIN_RATE_CONFIG, 8'h18);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, 1'b1, auxdf_pkg::ADDR_AUX_GAIN_RATE_CONFIG, auxdf_pkg::CFG_RESET);
      bus(1'b0, 1'b1, auxdf_pkg::ADDR_AUX_INPUT_MUX, auxdf_pkg::MUX_RESET);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      drain(10);
      end_of_test();
   end
endmodule : auxdf_top_tb
`default_nettype wire
